/* core/spi_audio_control_two.sv */
// What this block does
// RULE1: A set sign-extend bit makes receive reads sign extended, else zero filled.
// RULE2: A frame error raises an event only while its event enable is set.
// RULE3: A receive overflow raises an event only while its event enable is set.
// RULE4: A transmit underrun raises an event only while its event enable is set.
// RULE5: Ignored overflow keeps the held word; otherwise overflow stops the link.
// RULE6: Ignored underrun sends zeros; otherwise underrun stops the link.
// RULE7: The audio enable picks codec framing over plain serial framing.
// RULE8: Mono sends each transmit word on both left and right channels.
// RULE9: The format field picks standard, left, right or PCM framing.
// RULE10: Audio enable, mono and format accept writes only with the module off.
// RULE11: Mono and format act only while the audio enable is one.
// RULE12: Unimplemented bits read as zero and ignore writes.
// RULE13: An enabled error event holds the interrupt until its flag is cleared.
module spi_audio_control_two #(
	parameter int unsigned WORD_W = spi_audio_pkg::WORD_W_DEF
) (
	// Clock and reset
	input  wire logic                             SYS_CLK_I,
	input  wire logic                             RST_B_I,
	// Register port
	input  wire logic [spi_audio_pkg::ADDR_W-1:0] REG_ADDR_I,
	input  wire logic [spi_audio_pkg::DATA_W-1:0] REG_WDATA_I,
	input  wire logic                             REG_WR_I,
	input  wire logic                             REG_RD_I,
	output logic      [spi_audio_pkg::DATA_W-1:0] REG_RDATA_O,
	// Serial link
	input  wire logic                             SCK_I,
	input  wire logic                             FS_I,
	input  wire logic                             SDI_I,
	output logic                                  SDO_O,
	// Interrupt
	output logic                                  IRQ_O
);
	localparam int unsigned CNT_W = $clog2(WORD_W + 1);
	localparam int unsigned PAD_W = spi_audio_pkg::DATA_W - WORD_W;
	localparam logic [CNT_W-1:0] CNT_IDLE = CNT_W'(WORD_W);
	localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(WORD_W - 1);
	localparam logic [CNT_W-1:0] CNT_ZERO = '0;
	localparam logic [CNT_W-1:0] CNT_ONE  = CNT_W'(1);

	logic [2:0]                         s1_q;
	logic [2:0]                         s2_q;
	logic                               sck_last_q;
	logic                               fs_last_q;
	logic                               fs_sys_q;
	logic                               on_q;
	spi_audio_pkg::ctrl_two_s           ctl2_q;
	spi_audio_pkg::ctrl_two_s           ctl2_d;
	logic [spi_audio_pkg::EVT_W-1:0]    status_q;
	logic [spi_audio_pkg::EVT_W-1:0]    status_d;
	logic [spi_audio_pkg::EVT_W-1:0]    mask_q;
	logic [CNT_W-1:0]                   cnt_q;
	logic [CNT_W-1:0]                   cnt_d;
	logic [WORD_W-1:0]                  rx_shift_q;
	logic [WORD_W-1:0]                  rx_data_q;
	logic                               rx_full_q;
	logic [WORD_W-1:0]                  tx_buf_q;
	logic                               tx_full_q;
	logic [WORD_W-1:0]                  tx_shift_q;
	logic [WORD_W-1:0]                  tx_shift_d;
	logic [WORD_W-1:0]                  mono_word_q;
	logic                               loaded_q;
	logic                               right_q;
	logic                               halted_q;
	logic [spi_audio_pkg::DATA_W-1:0]   rdata_q;
	logic [spi_audio_pkg::DATA_W-1:0]   rd_val;

	// Address decode
	wire wr_ctl1 = REG_WR_I & (REG_ADDR_I == spi_audio_pkg::OFS_CTRL_ONE);
	wire wr_ctl2 = REG_WR_I & (REG_ADDR_I == spi_audio_pkg::OFS_CTRL_TWO);
	wire wr_mask = REG_WR_I & (REG_ADDR_I == spi_audio_pkg::OFS_MASK);
	wire wr_tx   = REG_WR_I & (REG_ADDR_I == spi_audio_pkg::OFS_TX);
	wire rd_stat = REG_RD_I & (REG_ADDR_I == spi_audio_pkg::OFS_STATUS);
	wire rd_rx   = REG_RD_I & (REG_ADDR_I == spi_audio_pkg::OFS_RX);

	// Synchronised link pins and their edges
	wire s_sck    = s2_q[2];
	wire s_fs     = s2_q[1];
	wire s_sdi    = s2_q[0];
	wire sck_rise = s_sck & ~sck_last_q;
	wire sck_fall = ~s_sck & sck_last_q;

	// Effective modes
	wire aud_en   = ctl2_q.audio_protocol_enable;                 // [RULE7]
	wire eff_mono = aud_en & ctl2_q.audio_mono_select;            // [RULE11]
	wire eff_pcm  = aud_en & (ctl2_q.audio_format_select ==
		spi_audio_pkg::FMT_PCM);                                    // [RULE9]
	wire eff_dly  = aud_en & (ctl2_q.audio_format_select ==
		spi_audio_pkg::FMT_I2S);                                    // [RULE9]
	wire run      = on_q & ~halted_q;

	// Word framing
	wire fs_edge  = eff_pcm ? (s_fs & ~fs_last_q) : (s_fs ^ fs_last_q);
	wire desel    = ~aud_en & s_fs;
	wire start    = aud_en ? fs_edge : (~s_fs & (cnt_q == CNT_IDLE));
	wire busy     = (cnt_q != CNT_IDLE) & (cnt_q != CNT_ZERO);
	wire last_bit = (cnt_q == CNT_LAST);
	wire dly_end  = eff_dly & last_bit; // Delayed last bit meets next edge
	wire frame_ev = run & busy & ((aud_en & sck_rise & fs_edge &
		~dly_end) | (~aud_en & s_fs & ~fs_sys_q));            // [RULE2]
	wire shift_in = run & sck_rise & ~desel &
		(start ? (~eff_dly | last_bit) : (cnt_q < CNT_IDLE)); // [RULE9]
	wire word_done = shift_in & (~start | eff_dly) & last_bit;
	wire [WORD_W-1:0] rx_next = {rx_shift_q[WORD_W-2:0], s_sdi};

	// Receive overflow and transmit load
	wire rov_cond = word_done & rx_full_q;
	wire rx_store = word_done & ~rx_full_q;                       // [RULE5]
	wire slot_gap = (cnt_q == CNT_IDLE) | (cnt_q == CNT_ZERO);
	wire load     = run & sck_fall & slot_gap & ~loaded_q;
	wire mono_rep = load & eff_mono & right_q;                    // [RULE8]
	wire take     = load & ~mono_rep;
	wire tur_cond = take & ~tx_full_q;
	wire shift_out = run & sck_fall & busy;

	// Events gated by their enables
	wire [spi_audio_pkg::EVT_W-1:0] evt = {
		tur_cond & ctl2_q.tx_underrun_event_enable,                // [RULE4]
		rov_cond & ctl2_q.rx_overflow_event_enable,                // [RULE3]
		frame_ev & ctl2_q.frame_error_event_enable                 // [RULE2]
	};
	wire stop_ev = (rov_cond & ~ctl2_q.ignore_rx_overflow) |      // [RULE5]
		(tur_cond & ~ctl2_q.ignore_tx_underrun);                    // [RULE6]

	// Receive word as read back
	wire [PAD_W-1:0] rx_pad = ctl2_q.rx_sign_extend ?
		{PAD_W{rx_data_q[WORD_W-1]}} : {PAD_W{1'b0}};               // [RULE1]

	// Second control register next value
	always_comb begin
		ctl2_d = ctl2_q;
		if (wr_ctl2) begin
			ctl2_d.rx_sign_extend = REG_WDATA_I[spi_audio_pkg::BIT_SIGN_EXT];
			ctl2_d.frame_error_event_enable =
				REG_WDATA_I[spi_audio_pkg::BIT_FRM_EN];
			ctl2_d.rx_overflow_event_enable =
				REG_WDATA_I[spi_audio_pkg::BIT_ROV_EN];
			ctl2_d.tx_underrun_event_enable =
				REG_WDATA_I[spi_audio_pkg::BIT_TUR_EN];
			ctl2_d.ignore_rx_overflow = REG_WDATA_I[spi_audio_pkg::BIT_IGN_ROV];
			ctl2_d.ignore_tx_underrun = REG_WDATA_I[spi_audio_pkg::BIT_IGN_TUR];
			if (!on_q) begin // [RULE10]
				ctl2_d.audio_protocol_enable =
					REG_WDATA_I[spi_audio_pkg::BIT_AUD_EN];
				ctl2_d.audio_mono_select = REG_WDATA_I[spi_audio_pkg::BIT_MONO];
				ctl2_d.audio_format_select = spi_audio_pkg::audio_fmt_e'(
					REG_WDATA_I[spi_audio_pkg::BIT_FMT_LO +: 2]);
			end
		end
	end

	// Read data select, unused bits zero
	always_comb begin
		rd_val = '0; // [RULE12]
		unique case (REG_ADDR_I)
			spi_audio_pkg::OFS_CTRL_ONE: rd_val[spi_audio_pkg::BIT_ON] = on_q;
			spi_audio_pkg::OFS_CTRL_TWO: begin
				rd_val[spi_audio_pkg::BIT_SIGN_EXT] = ctl2_q.rx_sign_extend;
				rd_val[spi_audio_pkg::BIT_FRM_EN] =
					ctl2_q.frame_error_event_enable;
				rd_val[spi_audio_pkg::BIT_ROV_EN] =
					ctl2_q.rx_overflow_event_enable;
				rd_val[spi_audio_pkg::BIT_TUR_EN] =
					ctl2_q.tx_underrun_event_enable;
				rd_val[spi_audio_pkg::BIT_IGN_ROV] = ctl2_q.ignore_rx_overflow;
				rd_val[spi_audio_pkg::BIT_IGN_TUR] = ctl2_q.ignore_tx_underrun;
				rd_val[spi_audio_pkg::BIT_AUD_EN] = aud_en;
				rd_val[spi_audio_pkg::BIT_MONO] = ctl2_q.audio_mono_select;
				rd_val[spi_audio_pkg::BIT_FMT_LO +: 2] =
					ctl2_q.audio_format_select;
			end
			spi_audio_pkg::OFS_STATUS: begin
				rd_val[spi_audio_pkg::EVT_W-1:0] = status_q;
				rd_val[spi_audio_pkg::ST_HALT] = halted_q;
			end
			spi_audio_pkg::OFS_MASK: rd_val[spi_audio_pkg::EVT_W-1:0] = mask_q;
			spi_audio_pkg::OFS_RX:   rd_val = {rx_pad, rx_data_q}; // [RULE1]
			default:                 rd_val = '0;
		endcase
	end

	// Bit counter next value
	always_comb begin
		cnt_d = cnt_q;
		if (!run || desel) begin
			cnt_d = CNT_IDLE;
		end else if (sck_rise && start) begin
			cnt_d = eff_dly ? CNT_ZERO : CNT_ONE; // [RULE9]
		end else if (shift_in) begin
			cnt_d = cnt_q + CNT_ONE;
		end
	end

	// Transmit shifter next value
	always_comb begin
		tx_shift_d = tx_shift_q;
		if (!run) begin
			tx_shift_d = '0;
		end else if (mono_rep) begin
			tx_shift_d = mono_word_q; // [RULE8]
		end else if (take) begin
			tx_shift_d = tx_full_q ? tx_buf_q : '0; // [RULE6]
		end else if (shift_out) begin
			tx_shift_d = {tx_shift_q[WORD_W-2:0], 1'b0};
		end
	end

	// Sticky flags, set wins over read clear
	assign status_d = evt | (status_q & ~{spi_audio_pkg::EVT_W{rd_stat}});
	assign IRQ_O = |(status_q & mask_q); // [RULE13]
	assign REG_RDATA_O = rdata_q;
	assign SDO_O = tx_shift_q[WORD_W-1];

	// Pin synchronisers and edge history
	always_ff @(posedge SYS_CLK_I) begin
		if (!RST_B_I) begin
			s1_q       <= 3'h0;
			s2_q       <= 3'h0;
			sck_last_q <= 1'b0;
			fs_sys_q   <= 1'b0;
		end else begin
			s1_q       <= {SCK_I, FS_I, SDI_I};
			s2_q       <= s1_q;
			sck_last_q <= s_sck;
			fs_sys_q   <= s_fs;
		end
	end

	// Software registers
	always_ff @(posedge SYS_CLK_I) begin
		if (!RST_B_I) begin
			on_q     <= 1'b0;
			ctl2_q   <= spi_audio_pkg::CTRL_TWO_RST;
			status_q <= spi_audio_pkg::STATUS_RST;
			mask_q   <= spi_audio_pkg::MASK_RST;
			rdata_q  <= '0;
		end else begin
			if (wr_ctl1) on_q <= REG_WDATA_I[spi_audio_pkg::BIT_ON];
			if (wr_mask) mask_q <= REG_WDATA_I[spi_audio_pkg::EVT_W-1:0];
			ctl2_q   <= ctl2_d;
			status_q <= status_d; // [RULE13]
			rdata_q  <= REG_RD_I ? rd_val : '0;
		end
	end

	// Receive path
	always_ff @(posedge SYS_CLK_I) begin
		if (!RST_B_I) begin
			cnt_q      <= CNT_IDLE;
			fs_last_q  <= 1'b0;
			rx_shift_q <= '0;
			rx_data_q  <= '0;
			rx_full_q  <= 1'b0;
			halted_q   <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			if (sck_rise) fs_last_q <= s_fs;
			if (shift_in) rx_shift_q <= rx_next;
			if (rx_store) rx_data_q <= rx_next;
			rx_full_q <= rx_store | (rx_full_q & ~rd_rx);
			halted_q  <= on_q & (halted_q | stop_ev); // [RULE5] [RULE6]
		end
	end

	// Transmit path
	always_ff @(posedge SYS_CLK_I) begin
		if (!RST_B_I) begin
			tx_buf_q    <= '0;
			tx_full_q   <= 1'b0;
			tx_shift_q  <= '0;
			mono_word_q <= '0;
			loaded_q    <= 1'b0;
			right_q     <= 1'b0;
		end else begin
			if (wr_tx) tx_buf_q <= REG_WDATA_I[WORD_W-1:0];
			tx_full_q  <= wr_tx | (tx_full_q & ~take);
			tx_shift_q <= tx_shift_d;
			if (take) mono_word_q <= tx_full_q ? tx_buf_q : '0;
			loaded_q <= run & (load | (loaded_q & slot_gap));
			right_q  <= run & aud_en & (right_q ^ load);
		end
	end

	default clocking cb @(posedge SYS_CLK_I); endclocking
	default disable iff (!RST_B_I);

	a_frame_gate: assert property ($rose(status_q[spi_audio_pkg::ST_FRM])
		|-> $past(ctl2_q.frame_error_event_enable)) // [RULE2]
		else $error("frame flag set while its enable was clear");
	a_rov_gate: assert property ((rov_cond & ~ctl2_q.rx_overflow_event_enable
		& ~status_q[spi_audio_pkg::ST_ROV] & ~rd_stat)
		|=> ~status_q[spi_audio_pkg::ST_ROV]) // [RULE3]
		else $error("overflow flag set while its enable was clear");
	a_tur_raise: assert property ((tur_cond & ctl2_q.tx_underrun_event_enable)
		|=> status_q[spi_audio_pkg::ST_TUR]) // [RULE4]
		else $error("enabled underrun did not set its flag");
	a_rov_keep: assert property ((rov_cond & ctl2_q.ignore_rx_overflow)
		|=> $stable(rx_data_q) & ~halted_q) // [RULE5]
		else $error("ignored overflow changed held data or halted");
	a_tur_zeros: assert property ((tur_cond & ctl2_q.ignore_tx_underrun)
		|=> tx_shift_q == '0 ##1 ~halted_q) // [RULE6]
		else $error("ignored underrun did not send zeros");
	a_stop_halt: assert property ((on_q & stop_ev) |=> halted_q [*2]
		or (halted_q ##1 ~on_q)) // [RULE5]
		else $error("critical error did not stop the link");
	a_locked_mode: assert property ((on_q & wr_ctl2)
		|=> $stable(ctl2_q.audio_protocol_enable)
		& $stable(ctl2_q.audio_format_select)) // [RULE10]
		else $error("audio mode changed while module on");
	a_rsvd_zero: assert property ((REG_RD_I &
		REG_ADDR_I == spi_audio_pkg::OFS_CTRL_TWO)
		|=> REG_RDATA_O[31:16] == 16'h0 && REG_RDATA_O[14:13] == 2'h0
		&& REG_RDATA_O[6:4] == 3'h0 && !REG_RDATA_O[2]) // [RULE12]
		else $error("unimplemented bits read nonzero");
	a_sign_ext: assert property ((rd_rx & ctl2_q.rx_sign_extend)
		|=> REG_RDATA_O[spi_audio_pkg::DATA_W-1] ==
		REG_RDATA_O[WORD_W-1]) // [RULE1]
		else $error("receive word not sign extended");
	a_mono_hold: assert property (mono_rep |=> tx_shift_q == $past(mono_word_q)
		&& !right_q) // [RULE8]
		else $error("mono right channel did not repeat word");
	a_irq_hold: assert property ((|(evt & mask_q)) |=> IRQ_O [*1]
		##1 (IRQ_O | $past(rd_stat))) // [RULE13]
		else $error("interrupt not held after enabled event");

	c_audio_word: cover property (word_done & aud_en);
	c_mono_repeat: cover property (mono_rep);
	c_ignored_rov: cover property (rov_cond & ctl2_q.ignore_rx_overflow);
	c_frame_err: cover property (frame_ev);
	c_delayed_word: cover property (word_done & eff_dly);
endmodule

/* core/spi_audio_pkg.sv */
package spi_audio_pkg;
	// Register bus shape
	localparam int unsigned ADDR_W     = 8;
	localparam int unsigned DATA_W     = 32;
	localparam int unsigned WORD_W_DEF = 16;

	// Register byte offsets
	localparam logic [7:0] OFS_CTRL_ONE = 8'h00;
	localparam logic [7:0] OFS_CTRL_TWO = 8'h04;
	localparam logic [7:0] OFS_STATUS   = 8'h08;
	localparam logic [7:0] OFS_MASK     = 8'h0c;
	localparam logic [7:0] OFS_TX       = 8'h10;
	localparam logic [7:0] OFS_RX       = 8'h14;

	// Control one field
	localparam int unsigned BIT_ON = 15;

	// Control two field positions
	localparam int unsigned BIT_SIGN_EXT = 15;
	localparam int unsigned BIT_FRM_EN   = 12;
	localparam int unsigned BIT_ROV_EN   = 11;
	localparam int unsigned BIT_TUR_EN   = 10;
	localparam int unsigned BIT_IGN_ROV  = 9;
	localparam int unsigned BIT_IGN_TUR  = 8;
	localparam int unsigned BIT_AUD_EN   = 7;
	localparam int unsigned BIT_MONO     = 3;
	localparam int unsigned BIT_FMT_LO   = 0;

	// Status and mask positions
	localparam int unsigned ST_FRM  = 0;
	localparam int unsigned ST_ROV  = 1;
	localparam int unsigned ST_TUR  = 2;
	localparam int unsigned ST_HALT = 3;
	localparam int unsigned EVT_W   = 3;

	// Audio framing choices
	typedef enum logic [1:0] {
		FMT_I2S   = 2'h0,
		FMT_LEFT  = 2'h1,
		FMT_RIGHT = 2'h2,
		FMT_PCM   = 2'h3
	} audio_fmt_e;

	// Second control register contents
	typedef struct packed {
		logic       rx_sign_extend;
		logic       frame_error_event_enable;
		logic       rx_overflow_event_enable;
		logic       tx_underrun_event_enable;
		logic       ignore_rx_overflow;
		logic       ignore_tx_underrun;
		logic       audio_protocol_enable;
		logic       audio_mono_select;
		audio_fmt_e audio_format_select;
	} ctrl_two_s;

	// Values after reset
	localparam ctrl_two_s        CTRL_TWO_RST = '0;
	localparam logic [EVT_W-1:0] STATUS_RST   = 3'h0;
	localparam logic [EVT_W-1:0] MASK_RST     = 3'h0;
endpackage

/* tb/codec_peer.sv */
module codec_peer #(
	parameter int W = 8
) (
	// Link pins
	output logic      sck_o,
	output logic      fs_o,
	output logic      sdi_o,
	input  wire logic sdo_i
);
	timeunit 1ns;
	timeprecision 1ns;

	// Words to send and words seen on the data out line
	logic [W-1:0] tx_w [4];
	logic [W-1:0] rx_w [4];

	// Bit clock stands low and the select is idle outside frames
	initial begin
		sck_o = 1'b0;
		fs_o = 1'b1;
		sdi_o = 1'b0;
		for (int i = 0; i < 4; i++) begin
			tx_w[i] = '0;
		end
	end

	// Sends n words msb first; cut aborts after that many bits
	// Dly moves the word edge one bit ahead of the msb
	task automatic frame(input int n, input bit aud, input int cut,
		input bit dly = 1'b0);
		#13;
		if (!aud)
			fs_o = 1'b0;
		#200;
		for (int w = 0; w < n; w++) begin
			for (int b = W - 1; b >= 0; b--) begin
				if (w * W + (W - 1 - b) == cut) begin
					fs_o = 1'b1;
					sdi_o = ~sdi_o;
					#200;
					return;
				end
				if (aud && b == (dly ? 0 : W - 1))
					fs_o = ~fs_o; // Word edge in codec framing
				sdi_o = tx_w[w][b];
				#200 sck_o = 1'b1;
				rx_w[w][b] = sdo_i;
				#200 sck_o = 1'b0;
			end
		end
		#200;
		if (!aud)
			fs_o = 1'b1;
		sdi_o = ~sdi_o; // Released line does not keep last bit
	endtask
endmodule

/* tb/test_spi_audio_control_two.sv */
module test_spi_audio_control_two;
	timeunit 1ns;
	timeprecision 1ns;

	localparam int W     = 8;
	localparam int LIMIT = 30000;
	localparam logic [7:0] c_one = spi_audio_pkg::OFS_CTRL_ONE;
	localparam logic [7:0] c_two = spi_audio_pkg::OFS_CTRL_TWO;
	localparam logic [7:0] st    = spi_audio_pkg::OFS_STATUS;
	localparam logic [7:0] mk    = spi_audio_pkg::OFS_MASK;
	localparam logic [7:0] txr   = spi_audio_pkg::OFS_TX;
	localparam logic [7:0] rxr   = spi_audio_pkg::OFS_RX;

	// Design pins
	logic        sys_clk = 1'b0;
	logic        rst_b   = 1'b0;
	logic [7:0]  addr    = 8'h00;
	logic [31:0] wdata   = 32'h0;
	logic        wr      = 1'b0;
	logic        rd      = 1'b0;
	logic [31:0] rdata;
	logic        sck;
	logic        fs;
	logic        sdi;
	logic        sdo;
	logic        irq;
	int          n_fail      = 0;
	int          checks_done = 0;
	int          cycles      = 0;

	always #25 sys_clk = ~sys_clk;

	spi_audio_control_two #(.WORD_W(W)) dut (
		.SYS_CLK_I(sys_clk), .RST_B_I(rst_b),
		.REG_ADDR_I(addr), .REG_WDATA_I(wdata),
		.REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdata),
		.SCK_I(sck), .FS_I(fs), .SDI_I(sdi), .SDO_O(sdo),
		.IRQ_O(irq)
	);

	codec_peer #(.W(W)) peer (
		.sck_o(sck), .fs_o(fs), .sdi_o(sdi), .sdo_i(sdo)
	);

	// Compare and count
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask

	// One-cycle register write
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge sys_clk);
		wr <= 1'b0;
	endtask

	// One-cycle read, data judged in the following cycle
	task automatic rd_reg(input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] e);
		@(posedge sys_clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge sys_clk);
		rd <= 1'b0;
		@(negedge sys_clk);
		chk(rdata & m, e);
	endtask

	// Mode written with the module off, then switched on
	task automatic setup(input logic [31:0] c, input logic [31:0] m);
		wr_reg(c_one, 32'h0);
		wr_reg(c_two, c);
		wr_reg(mk, m);
		rd_reg(st, 32'h0, 32'h0);
		rd_reg(rxr, 32'h0, 32'h0);
		wr_reg(c_one, 32'h8000);
	endtask

	// Reset value, reserved bits, lock while on, every format code
	task automatic t_regs();
		rd_reg(c_two, 32'hffffffff, 32'h0);
		wr_reg(c_two, 32'hffffffff);
		rd_reg(c_two, 32'hffffffff, 32'h9f8b);
		wr_reg(c_one, 32'h8000);
		wr_reg(c_two, 32'h0);
		rd_reg(c_two, 32'hffffffff, 32'h8b);
		wr_reg(c_one, 32'h0);
		for (int f = 0; f < 4; f++) begin
			wr_reg(c_two, 32'h80 | 32'(f));
			rd_reg(c_two, 32'hffffffff, 32'h80 | 32'(f));
		end
		rd_reg(8'h1c, 32'hffffffff, 32'h0);
	endtask

	// Negative word read with and without sign fill
	task automatic t_sign();
		for (int s = 0; s < 2; s++) begin
			setup(32'h0300 | (s ? 32'h8000 : 32'h0), 32'h0);
			peer.tx_w[0] = 8'h96;
			peer.frame(1, 1'b0, -1);
			rd_reg(rxr, 32'hffffffff, s ? 32'hffffff96 : 32'h96);
		end
	endtask

	// Two words unread: ignored keeps first, else halts
	task automatic t_ovf();
		for (int g = 1; g >= 0; g--) begin
			setup(32'h0900 | (32'(g) << 9), 32'h2);
			peer.tx_w[0] = 8'h5a;
			peer.tx_w[1] = 8'hc3;
			peer.frame(2, 1'b0, -1);
			chk({31'h0, irq}, 32'h1);
			rd_reg(st, 32'ha, g ? 32'h2 : 32'ha);
			chk({31'h0, irq}, 32'h0);
			if (g)
				rd_reg(rxr, 32'hffffffff, 32'h5a);
		end
	endtask

	// Empty transmit buffer: zeros when ignored, else halt
	task automatic t_tur();
		for (int g = 1; g >= 0; g--) begin
			setup(32'h0600 | (32'(g) << 8), 32'h4);
			wr_reg(txr, 32'he7);
			peer.frame(3, 1'b0, -1);
			if (g)
				chk({24'h0, peer.rx_w[2]}, 32'h0);
			chk({31'h0, irq}, 32'h1);
			rd_reg(st, 32'hc, g ? 32'h4 : 32'hc);
		end
	endtask

	// Aborted word, event enable off then on
	task automatic t_frm();
		for (int e = 0; e < 2; e++) begin
			setup(32'h0300 | (32'(e) << 12), 32'h1);
			peer.frame(1, 1'b0, 3);
			chk({31'h0, irq}, 32'(e));
			rd_reg(st, 32'h1, 32'(e));
		end
	endtask

	// Left-justified mono: one buffered word on both channels
	task automatic t_mono();
		logic ok;
		ok = 1'b0;
		setup(32'h0389, 32'h0);
		wr_reg(txr, 32'ha5);
		peer.frame(4, 1'b1, -1);
		for (int i = 0; i < 3; i++) begin
			if (peer.rx_w[i] === 8'ha5 && peer.rx_w[i + 1] === 8'ha5)
				ok = 1'b1;
		end
		chk({31'h0, ok}, 32'h1);
	endtask

	// Standard format: edge one bit ahead of the msb, no false frame error
	task automatic t_i2s();
		setup(32'h1380, 32'h1);
		wr_reg(txr, 32'h69);
		peer.tx_w[1] = 8'h3c;
		peer.frame(2, 1'b1, -1, 1'b1);
		chk({24'h0, peer.rx_w[1]}, 32'h69);
		rd_reg(rxr, 32'hffffffff, 32'h3c);
		rd_reg(st, 32'h1, 32'h0);
	endtask

	// Verdict and end of run
	task automatic close_out();
		$display("checks %0d, mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// Main sequence
	initial begin
		repeat (12) @(posedge sys_clk);
		rst_b <= 1'b1;
		t_regs();
		t_sign();
		t_ovf();
		t_tur();
		t_frm();
		t_mono();
		t_i2s();
		close_out();
	end

	// Hang guard
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == LIMIT) begin
			n_fail++;
			close_out();
		end
	end
endmodule
